// File: logic/lcr_pkg.sv
// Package of register map, field layout and reset values for the config bank
package lcr_pkg;
    localparam logic [7:0] LCR_ADDR_LEADOFF = 8'h03;
    localparam logic [7:0] LCR_ADDR_CH_ONE = 8'h04;
    localparam logic [7:0] LCR_ADDR_CONFIG_TWO = 8'h02;
    localparam logic [7:0] LCR_RST_LEADOFF = 8'h10;
    localparam logic [7:0] LCR_RST_CH_ONE = 8'h00;
    localparam logic [7:0] LCR_RST_CONFIG_TWO = 8'h80;
    localparam logic [7:0] LCR_FIXED_MASK_LEADOFF = 8'h12;
    localparam logic [7:0] LCR_FIXED_VAL_LEADOFF = 8'h10;
    localparam logic [7:0] LCR_FIXED_MASK_CONFIG_TWO = 8'h84;
    localparam logic [7:0] LCR_FIXED_VAL_CONFIG_TWO = 8'h80;
    localparam int LCR_POS_THRESH = 5;
    localparam int LCR_POS_CURRENT = 2;
    localparam int LCR_POS_AC = 0;
    localparam int LCR_POS_PWRDN = 7;
    localparam int LCR_POS_GAIN = 4;
    localparam int LCR_POS_INSEL = 0;
    localparam int LCR_POS_COMP_EN = 6;

    typedef enum logic [3:0]
    {
        LCR_IN_NORMAL = 4'b0000,
        LCR_IN_SHORTED = 4'b0001,
        LCR_IN_DRIVE_MEASURE = 4'b0010,
        LCR_IN_SUPPLY_MON = 4'b0011,
        LCR_IN_TEMP = 4'b0100,
        LCR_IN_TEST = 4'b0101,
        LCR_IN_DRIVE_POS = 4'b0110,
        LCR_IN_DRIVE_NEG = 4'b0111,
        LCR_IN_DRIVE_BOTH = 4'b1000,
        LCR_IN_THIRD_PAIR = 4'b1001
    } lcr_insel_e;

    typedef struct packed
    {
        logic [2:0] detect_threshold_code;
        logic [1:0] excitation_current_code;
        logic detect_ac_select;
        logic comparator_power_enable;
    } lcr_leadoff_s;

    typedef struct packed
    {
        logic ch_one_powerdown;
        logic [2:0] ch_one_gain_code;
        logic [3:0] ch_one_input_select;
        logic normal_input;
        logic shorted_input;
        logic drive_measure_input;
        logic supply_monitor_input;
        logic temp_input;
        logic test_input;
        logic drive_to_positive_input;
        logic drive_to_negative_input;
        logic third_pair_input;
    } lcr_ch_one_s;
endpackage

// File: logic/lcr_bank.sv
// Lead-off and channel one configuration register bank
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
//
// Contract
// - Lead-off register at 0x03 holds threshold, current and frequency fields.
// - Lead-off bits 7:5 pick one of eight threshold pairs, 000 default.
// - Lead-off bit 0 picks dc (0, default) or ac detection.
// - Channel one register at 0x04: powerdown, gain, input select.
// - Channel one bit 7 set powers the channel down; clear by default.
// - Channel one bits 6:4 are the gain code, 000 default.
// - Channel one bits 3:0 select the input source, 0000 default.
// - Input codes 0110, 0111, 1000 tie drive input to pos, neg, both.
// - Lead-off comparators powered only when config two bit 6 set.
module lcr_bank
    import lcr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output lcr_leadoff_s leadoff_o,
    output lcr_ch_one_s ch_one_o
);
    logic [7:0] leadoff_q;
    logic [7:0] leadoff_d;
    logic [7:0] ch_one_q;
    logic [7:0] ch_one_d;
    logic [7:0] cfg_two_q;
    logic [7:0] cfg_two_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    lcr_leadoff_s leadoff_q2;
    lcr_leadoff_s leadoff_d2;
    lcr_ch_one_s ch_one_q2;
    lcr_ch_one_s ch_one_d2;
    wire logic hit_leadoff;
    wire logic hit_ch_one;
    wire logic hit_cfg_two;
    wire logic [3:0] insel;
    wire logic [9:0] insel_hot;
    wire logic [7:0] ch_one_src;

    // Address decode
    assign hit_leadoff = reg_addr_i == LCR_ADDR_LEADOFF;
    assign hit_ch_one = reg_addr_i == LCR_ADDR_CH_ONE;
    assign hit_cfg_two = reg_addr_i == LCR_ADDR_CONFIG_TWO;

    // Write paths, fixed bits forced
    assign leadoff_d = (reg_wr_i && hit_leadoff) ?
        ((reg_wdata_i & ~LCR_FIXED_MASK_LEADOFF) | LCR_FIXED_VAL_LEADOFF) :
        leadoff_q;
    assign ch_one_d = (reg_wr_i && hit_ch_one) ? reg_wdata_i :
        ch_one_q;
    assign cfg_two_d = (reg_wr_i && hit_cfg_two) ?
        ((reg_wdata_i & ~LCR_FIXED_MASK_CONFIG_TWO) |
        LCR_FIXED_VAL_CONFIG_TWO) : cfg_two_q;

    // Read mux, unmapped reads zero
    assign rdata_d = !reg_rd_i ? 8'h00 :
        hit_leadoff ? leadoff_q :
        hit_ch_one ? ch_one_q :
        hit_cfg_two ? cfg_two_q : 8'h00;

    // Field decode of the next values
    assign leadoff_d2.detect_threshold_code =
        leadoff_d[LCR_POS_THRESH +: 3];
    assign leadoff_d2.excitation_current_code =
        leadoff_d[LCR_POS_CURRENT +: 2];
    assign leadoff_d2.detect_ac_select = leadoff_d[LCR_POS_AC];
    assign leadoff_d2.comparator_power_enable =
        cfg_two_d[LCR_POS_COMP_EN];
    // Decode follows the reset value while reset is held
    assign ch_one_src = sys_rst_i ? LCR_RST_CH_ONE : ch_one_d;
    assign insel = ch_one_src[LCR_POS_INSEL +: 4];
    assign ch_one_d2.ch_one_powerdown = ch_one_src[LCR_POS_PWRDN];
    assign ch_one_d2.ch_one_gain_code =
        ch_one_src[LCR_POS_GAIN +: 3];
    assign ch_one_d2.ch_one_input_select = insel;

    // One-hot source decode; reserved codes select nothing
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_hot
            assign insel_hot[gi] = insel == 4'(gi);
        end
    endgenerate
    assign ch_one_d2.normal_input = insel_hot[LCR_IN_NORMAL];
    assign ch_one_d2.shorted_input = insel_hot[LCR_IN_SHORTED];
    assign ch_one_d2.drive_measure_input = insel_hot[LCR_IN_DRIVE_MEASURE];
    assign ch_one_d2.supply_monitor_input = insel_hot[LCR_IN_SUPPLY_MON];
    assign ch_one_d2.temp_input = insel_hot[LCR_IN_TEMP];
    assign ch_one_d2.test_input = insel_hot[LCR_IN_TEST];
    assign ch_one_d2.drive_to_positive_input = insel_hot[LCR_IN_DRIVE_POS] ||
        insel_hot[LCR_IN_DRIVE_BOTH];
    assign ch_one_d2.drive_to_negative_input = insel_hot[LCR_IN_DRIVE_NEG] ||
        insel_hot[LCR_IN_DRIVE_BOTH];
    assign ch_one_d2.third_pair_input = insel_hot[LCR_IN_THIRD_PAIR];

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            leadoff_q <= LCR_RST_LEADOFF;
            ch_one_q <= LCR_RST_CH_ONE;
            cfg_two_q <= LCR_RST_CONFIG_TWO;
            rdata_q <= 8'h00;
            leadoff_q2 <= '0;
            ch_one_q2 <= ch_one_d2;
        end
        else if (clk_en_i)
        begin
            leadoff_q <= leadoff_d;
            ch_one_q <= ch_one_d;
            cfg_two_q <= cfg_two_d;
            rdata_q <= rdata_d;
            leadoff_q2 <= leadoff_d2;
            ch_one_q2 <= ch_one_d2;
        end
    end

    // Outputs straight from the registers
    assign reg_rdata_o = rdata_q;
    assign leadoff_o = leadoff_q2;
    assign ch_one_o = ch_one_q2;

    // Storage and decode checks
    AST_LEADOFF_FIXED: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) (leadoff_q & LCR_FIXED_MASK_LEADOFF) ==
        LCR_FIXED_VAL_LEADOFF)
        else $error("Lead-off fixed bits wrong");
    AST_LEADOFF_WRITE: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_wr_i && hit_leadoff |=>
        leadoff_q[7:5] == $past(reg_wdata_i[7:5]) &&
        leadoff_q[3:2] == $past(reg_wdata_i[3:2]) &&
        leadoff_q[0] == $past(reg_wdata_i[0]))
        else $error("Lead-off write lost");
    AST_THRESH_OUT: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_wr_i && hit_leadoff |=>
        leadoff_o.detect_threshold_code == $past(reg_wdata_i[7:5]))
        else $error("Threshold output wrong");
    AST_CURRENT_OUT: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ##1 1'b1 |->
        leadoff_o.excitation_current_code == leadoff_q[3:2])
        else $error("Current output wrong");
    AST_AC_OUT: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ##1 1'b1 |->
        leadoff_o.detect_ac_select == leadoff_q[0])
        else $error("Detect mode output wrong");
    AST_CH_WRITE: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_wr_i && hit_ch_one |=>
        ch_one_q == $past(reg_wdata_i) &&
        ch_one_o.ch_one_powerdown == $past(reg_wdata_i[7]) &&
        ch_one_o.ch_one_gain_code == $past(reg_wdata_i[6:4]))
        else $error("Channel one write lost");
    AST_GAIN_HOLD: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) !(reg_wr_i && hit_ch_one) |=>
        $stable(ch_one_q))
        else $error("Channel one changed without write");
    AST_DRIVE_BOTH: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_wr_i && hit_ch_one &&
        reg_wdata_i[3:0] == 4'h8 |=> ch_one_o.drive_to_positive_input &&
        ch_one_o.drive_to_negative_input && !ch_one_o.normal_input)
        else $error("Drive both decode wrong");
    AST_INSEL_OUT: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ##1 1'b1 |->
        ch_one_o.ch_one_input_select == ch_one_q[3:0] &&
        ch_one_o.normal_input == (ch_one_q[3:0] == 4'h0))
        else $error("Input select output wrong");
    AST_READ: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_rd_i && hit_ch_one |=>
        reg_rdata_o == $past(ch_one_q) && $stable(ch_one_q))
        else $error("Read data wrong");
    AST_COMP_EN: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ##1 1'b1 |->
        leadoff_o.comparator_power_enable == cfg_two_q[6])
        else $error("Comparator enable wrong");
    AST_RESET_STATE: assert property (@(posedge core_clk_i)
        $fell(sys_rst_i) |-> ch_one_q == LCR_RST_CH_ONE &&
        leadoff_q == LCR_RST_LEADOFF && ch_one_o.normal_input &&
        !ch_one_o.ch_one_powerdown)
        else $error("Reset state wrong");
    AST_LEADOFF_HOLD: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) !(clk_en_i && reg_wr_i && hit_leadoff) |=>
        $stable(leadoff_q))
        else $error("Lead-off changed without write");
    AST_RDATA_IDLE: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && !reg_rd_i |=>
        reg_rdata_o == 8'h00)
        else $error("Read data not cleared");
    AST_UNMAPPED_READ: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_rd_i && !hit_leadoff &&
        !hit_ch_one && !hit_cfg_two |=> reg_rdata_o == 8'h00)
        else $error("Unmapped read not zero");
    AST_SUPPLY_FLAG: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) clk_en_i && reg_wr_i && hit_ch_one &&
        reg_wdata_i[3:0] == LCR_IN_SUPPLY_MON |=>
        ch_one_o.supply_monitor_input && !ch_one_o.normal_input)
        else $error("Supply monitor decode wrong");
    AST_RESERVED_NONE: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) ch_one_o.ch_one_input_select > 4'h9 |->
        ch_one_o[8:0] == 9'h000)
        else $error("Reserved input code set a flag");

    // Main scenarios
    COV_LEADOFF_WR: cover property (@(posedge core_clk_i)
        reg_wr_i && hit_leadoff && clk_en_i);
    COV_CH_RD: cover property (@(posedge core_clk_i)
        reg_rd_i && hit_ch_one && clk_en_i);
    COV_PWRDN: cover property (@(posedge core_clk_i)
        ch_one_o.ch_one_powerdown && ch_one_o.shorted_input);
    COV_DRIVE_BOTH: cover property (@(posedge core_clk_i)
        ch_one_o.drive_to_positive_input && ch_one_o.drive_to_negative_input);
    COV_FREEZE: cover property (@(posedge core_clk_i)
        !clk_en_i && reg_wr_i && hit_ch_one);
endmodule

// File: verif/tb.sv
// Self-checking testbench for the lead-off and channel one register bank
`timescale 1ns/100ps
module tb;
    import lcr_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    lcr_leadoff_s leadoff_o;
    lcr_ch_one_s ch_one_o;
    logic [7:0] rv;
    int n_mismatch = 0;
    int check_count = 0;

    always #12.5 core_clk_i = ~core_clk_i;

    lcr_bank lcr_bank_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .leadoff_o(leadoff_o),
        .ch_one_o(ch_one_o)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; outputs settle after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic test_reset();
        rd(LCR_ADDR_LEADOFF, rv);
        check(rv, 8'h10);
        rd(LCR_ADDR_CH_ONE, rv);
        check(rv, 8'h00);
        rd(LCR_ADDR_CONFIG_TWO, rv);
        check(rv, 8'h80);
        check(leadoff_o, 16'h0000);
        check(ch_one_o[16:9], 8'h00);
        check(ch_one_o[8:0], 9'h100);
        @(posedge core_clk_i);
        #1;
        check(reg_rdata_o, 8'h00);
    endtask

    // Every threshold, current and mode code, fixed bits written as asked
    task automatic test_leadoff();
        for (int t = 0; t < 8; t++)
        begin
            wr(8'h03, {t[2:0], 1'b1, t[1:0], 1'b0, t[0]});
            rd(8'h03, rv);
            check(rv, {t[2:0], 1'b1, t[1:0], 1'b0, t[0]});
            check({leadoff_o[6:1]}, {t[2:0], t[1:0], t[0]});
        end
    endtask

    // Every input select code; power-down only with inputs shorted
    task automatic test_ch_one();
        logic [7:0] d;
        logic [8:0] f;
        logic [2:0] g;
        for (int c = 0; c < 16; c++)
        begin
            g = (c == 3) ? 3'h1 : 3'(c % 7);
            d = {c == 1, g, 4'(c)};
            f = {c == 0, c == 1, c == 2, c == 3, c == 4, c == 5,
                c == 6 || c == 8, c == 7 || c == 8, c == 9};
            wr(8'h04, d);
            check(ch_one_o[16:9], d);
            check(ch_one_o[8:0], f);
            rd(8'h04, rv);
            check(rv, d);
        end
    endtask

    task automatic test_misc();
        wr(LCR_ADDR_CONFIG_TWO, 8'hc0);
        check(leadoff_o.comparator_power_enable, 1'b1);
        rd(LCR_ADDR_CONFIG_TWO, rv);
        check(rv, 8'hc0);
        wr(8'h05, 8'hff);
        rd(8'h05, rv);
        check(rv, 8'h00);
        wr(LCR_ADDR_CH_ONE, 8'h81);
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(LCR_ADDR_CH_ONE, 8'h11);
        @(posedge core_clk_i);
        clk_en_i <= 1'b1;
        #1;
        check(ch_one_o[16:9], 8'h81);
        rd(LCR_ADDR_CH_ONE, rv);
        check(rv, 8'h81);
    endtask

    // Reset in mid-run brings back the lead-off and channel one reset values
    task automatic test_mid_reset();
        wr(LCR_ADDR_LEADOFF, 8'hf5);
        wr(LCR_ADDR_CH_ONE, 8'h81);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check(leadoff_o, 16'h0000);
        check(ch_one_o[16:9], 8'h00);
        check(ch_one_o[8:0], 9'h100);
        rd(LCR_ADDR_LEADOFF, rv);
        check(rv, 8'h10);
        rd(LCR_ADDR_CH_ONE, rv);
        check(rv, 8'h00);
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        test_reset();
        test_leadoff();
        test_ch_one();
        test_misc();
        test_mid_reset();
        test_done();
    end

    initial
    begin
        #20000;
        n_mismatch++;
        test_done();
    end
endmodule
